//--- usw_pkg.sv
// Package for the USB status / wake / receive-activity indicator block.
// Assumes a single 100 MHz core clock domain; no software register bus.
package usw_pkg;

  // Core clock
  localparam int unsigned CLK_HZ          = 100_000_000;

  // Receive activity toggle: about 10 Hz, so one half period of 50 ms
  localparam int unsigned RX_TOGGLE_MS    = 50;
  localparam int unsigned RX_TOGGLE_CYC   = (CLK_HZ / 1000) * RX_TOGGLE_MS;

  // Power draw threshold in bMaxPower units (one unit load)
  localparam logic [7:0]  MAX_POWER_LOW   = 8'h32;

  // Status pin configuration field layout
  localparam int unsigned CFG_W           = 4;
  localparam int unsigned CFG_POL_BIT     = 0;  // 1: active high
  localparam int unsigned CFG_RESET_BIT   = 1;
  localparam int unsigned CFG_SUSP_BIT    = 2;
  localparam int unsigned CFG_POWER_BIT   = 3;
  localparam logic [CFG_W-1:0] CFG_RESET_VAL = 4'h5; // active high, suspend only

  // Wake pulse length in core cycles
  localparam int unsigned WAKE_PULSE_CYC  = 1;

endpackage

//--- usw_toggle_timer.sv
// Free toggling divider for the receive activity pin.
// Assumes one clock domain; run is a synchronous level.
`timescale 1ns/1ns
module usw_toggle_timer #(
  parameter int unsigned HALF_CYC = 5_000_000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Control and output
  input  wire logic run,
  output logic      tog_out
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);

  // Elaboration guard: a shorter half period cannot wrap
  if (HALF_CYC < 2) begin : g_bad_half
    $error("HALF_CYC must be at least 2");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tog_reg;
  logic          wrap;

  // Counter wraps at the half period; it pauses while idle
  assign wrap     = run && (cnt_reg == CW'(HALF_CYC - 1));
  assign cnt_next = !run ? cnt_reg : (wrap ? '0 : cnt_reg + CW'(1));
  assign tog_out  = tog_reg;

  // Level freezes when idle so the pin does not flicker between bursts
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tog_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_reg ^ wrap;
    end
  end
endmodule

//--- usw_status_wake.sv
// Summary of operation
// - Reset selection asserts status output during host bus reset.
// - Suspend selection asserts status output while device is suspended.
// - Power-safe with bMaxPower at or below 0x32: assert only while suspended.
// - Power-safe with bMaxPower above 0x32: assert when suspended or unconfigured.
// - Configuration picks status polarity and which conditions drive it.
// - Status output deasserted whenever no selected condition holds.
// - After reset: active high, asserted only while suspended.
// - Falling edge on enabled wake input requests remote wakeup to host.
// - Enabled receive indicator toggles near 10 Hz while UART receives.
//
// Top of the status, wake and receive-activity logic.
// Assumes USB state inputs come from the device core, synchronous to ref_clk.
`timescale 1ns/1ns
module usw_status_wake #(
  parameter int unsigned RX_HALF_CYC = usw_pkg::RX_TOGGLE_CYC
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  // USB device state
  input  wire logic                     usb_bus_reset,
  input  wire logic                     usb_suspended,
  input  wire logic                     usb_configured,
  input  wire logic [7:0]               max_power,
  // Status pin configuration
  input  wire logic                     cfg_load,
  input  wire logic [usw_pkg::CFG_W-1:0] status_pin_config,
  output logic      [usw_pkg::CFG_W-1:0] status_cfg_active,
  output logic                          usb_status_out,
  // Remote wakeup
  input  wire logic                     wake_enable,
  input  wire logic                     remote_wake_in,
  output logic                          wake_request,
  // Receive activity
  input  wire logic                     rx_ind_enable,
  input  wire logic                     uart_rx_busy,
  output logic                          rx_activity_out
);
  import usw_pkg::*;

  // Elaboration guard: the divider cannot wrap below two cycles
  if (RX_HALF_CYC < 2) begin : g_bad_half
    $error("RX_HALF_CYC too small");
  end

  logic [CFG_W-1:0] cfg_reg;
  logic             stat_reg;
  logic             stat_next;
  logic             wake_prev_reg;
  logic             wake_reg;
  logic             rx_pin_reg;
  logic             tog;
  logic             cond_power;
  logic             cond_any;
  logic             high_power;
  logic             wake_fall;
  logic             cfg_power_only;

  // Condition decode; power-safe depends on the requested draw
  assign high_power = max_power > MAX_POWER_LOW;
  assign cond_power = usb_suspended || (high_power && !usb_configured);
  // Any selected condition asserts; none selected holding deasserts
  assign cond_any = (cfg_reg[CFG_RESET_BIT] && usb_bus_reset)
                 || (cfg_reg[CFG_SUSP_BIT]  && usb_suspended)
                 || (cfg_reg[CFG_POWER_BIT] && cond_power);
  // Polarity bit set means active high
  assign stat_next = cond_any ~^ cfg_reg[CFG_POL_BIT];
  assign wake_fall = wake_enable && wake_prev_reg && !remote_wake_in;
  // Power-safe alone and active high; the power checks watch this code only
  assign cfg_power_only = cfg_reg[CFG_POWER_BIT] && cfg_reg[CFG_POL_BIT]
                       && !cfg_reg[CFG_RESET_BIT] && !cfg_reg[CFG_SUSP_BIT];

  assign usb_status_out    = stat_reg;
  assign status_cfg_active = cfg_reg;
  assign wake_request      = wake_reg;
  assign rx_activity_out   = rx_pin_reg;

  // Configuration; reset value gives active high, suspend only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= CFG_RESET_VAL;
    end else if (cfg_load) begin
      cfg_reg <= status_pin_config;
    end
  end

  // Status pin registered so it never glitches on decode changes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Wake edge detect; previous level starts high as the pin is pulled up
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_prev_reg <= 1'b1;
      wake_reg      <= 1'b0;
    end else begin
      wake_prev_reg <= remote_wake_in;
      wake_reg      <= wake_fall;
    end
  end

  // Receive activity divider
  usw_toggle_timer #(
    .HALF_CYC (RX_HALF_CYC)
  ) u_rx_tog (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (rx_ind_enable && uart_rx_busy),
    .tog_out (tog)
  );

  // Indicator parks low while the pin serves another use
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_pin_reg <= 1'b0;
    end else begin
      rx_pin_reg <= rx_ind_enable && tog;
    end
  end

  // Assertions
  sequence s_fall;
    wake_enable && $fell(remote_wake_in);
  endsequence

  sequence s_pulse;
    ##1 wake_request ##1 !wake_request;
  endsequence

  property p_reset_cond;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_reg[CFG_RESET_BIT] && usb_bus_reset && !cfg_load)
        |=> usb_status_out == cfg_reg[CFG_POL_BIT];
  endproperty
  a_reset_cond: assert property (p_reset_cond) else $error("reset cond not shown");

  property p_susp_cond;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_reg[CFG_SUSP_BIT] && usb_suspended && !cfg_load)
        |=> usb_status_out == cfg_reg[CFG_POL_BIT];
  endproperty
  a_susp_cond: assert property (p_susp_cond) else $error("suspend cond not shown");

  property p_low_power;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_power_only && max_power <= MAX_POWER_LOW && !cfg_load)
        |=> usb_status_out == $past(usb_suspended);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power status wrong");

  property p_high_power;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_power_only && max_power > MAX_POWER_LOW && !cfg_load)
        |=> usb_status_out == ($past(usb_suspended) || !$past(usb_configured));
  endproperty
  a_high_power: assert property (p_high_power) else $error("high power status wrong");

  property p_polarity;
    @(posedge ref_clk) disable iff (!nrst)
      (!cfg_load && !cfg_reg[CFG_POL_BIT] && !cond_any) |=> usb_status_out;
  endproperty
  a_polarity: assert property (p_polarity) else $error("low polarity idle wrong");

  property p_deassert;
    @(posedge ref_clk) disable iff (!nrst)
      (!cond_any && !cfg_load && cfg_reg[CFG_POL_BIT]) |=> !usb_status_out;
  endproperty
  a_deassert: assert property (p_deassert) else $error("status not deasserted");

  property p_default;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_reg == CFG_RESET_VAL && !cfg_load)
        |=> usb_status_out == $past(usb_suspended);
  endproperty
  a_default: assert property (p_default) else $error("default status wrong");

  property p_wake;
    @(posedge ref_clk) disable iff (!nrst)
      s_fall |-> s_pulse;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse missing");

  property p_rx_idle;
    @(posedge ref_clk) disable iff (!nrst)
      !rx_ind_enable |=> !rx_activity_out;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rx indicator not parked");

  property p_any;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg_reg[CFG_POL_BIT] && !cfg_load && cfg_reg[CFG_RESET_BIT] && cfg_reg[CFG_SUSP_BIT]
        && (usb_bus_reset || usb_suspended)) |=> usb_status_out;
  endproperty
  a_any: assert property (p_any) else $error("combined conditions wrong");

  property p_cfg_load;
    @(posedge ref_clk) disable iff (!nrst)
      cfg_load |=> status_cfg_active == $past(status_pin_config);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

  property p_cfg_hold;
    @(posedge ref_clk) disable iff (!nrst)
      !cfg_load |=> $stable(status_cfg_active);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unasked");

  property p_wake_off;
    @(posedge ref_clk) disable iff (!nrst)
      !wake_enable |=> !wake_request;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");

  property p_rx_follow;
    @(posedge ref_clk) disable iff (!nrst)
      rx_ind_enable |=> rx_activity_out == $past(tog);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx indicator lost");

  // A pause freezes the indicator level, so it never flickers between bursts
  property p_rx_pause;
    @(posedge ref_clk) disable iff (!nrst)
      (rx_ind_enable && $past(rx_ind_enable && !uart_rx_busy)) |=> $stable(rx_activity_out);
  endproperty
  a_rx_pause: assert property (p_rx_pause) else $error("rx indicator moved idle");

endmodule

//--- usw_host_model.sv
// Host and board model: USB state levels and a wake button.
// Assumes the bench calls its tasks; changes land on falling edges.
`timescale 1ns/1ns
module usw_host_model (
  // Clock
  input  wire logic ref_clk,
  // USB state and wake pin
  output logic       bus_rst,
  output logic       susp,
  output logic       conf,
  output logic [7:0] mp,
  output logic       wake_pin
);
  // Pin idles high, like a pulled-up input; host starts with the device suspended
  initial begin
    {bus_rst, susp, conf, mp, wake_pin} = {3'b010, 8'h00, 1'b1};
  end
  // State word is {bus reset, suspended, configured, max power}
  task automatic set(input logic [10:0] s);
    @(negedge ref_clk);
    {bus_rst, susp, conf, mp} = s;
  endtask
  // Press holds the pin low for n cycles so the fall is seen
  task automatic press(input int n);
    @(negedge ref_clk);
    wake_pin = 1'b0;
    repeat (n) @(negedge ref_clk);
    wake_pin = 1'b1;
  endtask
endmodule

//--- tb.sv
// Self-checking bench for the status, wake and rx indicator top.
// Assumes the host model drives USB state and the wake pin; the bench drives the rest.
`timescale 1ns/1ns
module tb;
  import usw_pkg::*;
  localparam int HALF = 4;
  // Table entries are {config, bus reset, suspended, configured, max power}
  localparam logic [14:0] TBL [11] = '{15'h1c00, 15'h1800, 15'h2a00, 15'h2800,
    15'h4832, 15'h4833, 15'h4933, 15'h4a32, 15'h2200, 15'h2000, 15'h3c00};
  logic             ref_clk, nrst, cfg_load, wake_enable, rx_ind_enable, uart_rx_busy;
  logic             bus_rst, susp, conf, wake_pin, stat, wreq, rxo;
  logic [7:0]       mp;
  logic [CFG_W-1:0] cfg, cfg_act;
  int               bad_count, n_checks, cyc;
  // Short rx half period keeps the run brief
  usw_host_model u_host (.ref_clk(ref_clk), .bus_rst(bus_rst), .susp(susp), .conf(conf),
    .mp(mp), .wake_pin(wake_pin));
  usw_status_wake #(.RX_HALF_CYC(HALF)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
    .usb_bus_reset(bus_rst), .usb_suspended(susp), .usb_configured(conf), .max_power(mp),
    .cfg_load(cfg_load), .status_pin_config(cfg), .status_cfg_active(cfg_act),
    .usb_status_out(stat), .wake_enable(wake_enable), .remote_wake_in(wake_pin),
    .wake_request(wreq), .rx_ind_enable(rx_ind_enable), .uart_rx_busy(uart_rx_busy),
    .rx_activity_out(rxo));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the roughly 155 cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Status level worked out from config bits and host state
  function automatic logic f_exp(input logic [3:0] c, input logic [10:0] s);
    logic cond;
    cond = (c[1] & s[10]) | (c[2] & s[9]) | (c[3] & (s[9] | (s[7:0] > 8'h32 & !s[8])));
    return c[0] ? cond : !cond;
  endfunction
  task automatic test_reset();
    repeat (2) @(negedge ref_clk);
    check(cfg_act, CFG_RESET_VAL, "reset config");
    check(stat, 8'h01, "default suspend");
    $display("test reset done");
  endtask
  // Each entry reloads config, with successive loads six cycles apart
  task automatic test_status();
    for (int i = 0; i < 11; i++) begin
      @(negedge ref_clk);
      cfg = TBL[i][14:11];
      cfg_load = 1'b1;
      @(negedge ref_clk);
      cfg_load = 1'b0;
      u_host.set(TBL[i][10:0]);
      repeat (3) @(negedge ref_clk);
      check(cfg_act, TBL[i][14:11], "config");
      check(stat, f_exp(TBL[i][14:11], TBL[i][10:0]), "status");
    end
    $display("test status done");
  endtask
  // Reset in mid-run returns every output and the config to defaults
  task automatic test_midreset();
    u_host.set(11'h200);
    @(negedge ref_clk);
    nrst = 1'b0;
    @(negedge ref_clk);
    check(stat, 8'h00, "status in reset");
    check(cfg_act, CFG_RESET_VAL, "config in reset");
    check({wreq, rxo}, 8'h00, "pulses in reset");
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(stat, 8'h01, "suspend after reset");
    $display("test midreset done");
  endtask
  // Enabled press gives one pulse, disabled press none
  task automatic test_wake();
    int n;
    for (int e = 1; e >= 0; e--) begin
      @(negedge ref_clk);
      wake_enable = e[0];
      n = 0;
      fork
        u_host.press(3);
        repeat (8) @(posedge ref_clk) #1 if (wreq === 1'b1) n++;
      join
      check(n[7:0], e[7:0], "wake pulses");
    end
    $display("test wake done");
  endtask
  // Sixteen running cycles hold four toggles whatever the phase
  task automatic test_rx();
    int t;
    logic last;
    @(negedge ref_clk);
    rx_ind_enable = 1'b1;
    uart_rx_busy = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int ph = 0; ph < 2; ph++) begin
      t = 0;
      last = rxo;
      repeat (16) begin
        @(negedge ref_clk);
        if (rxo !== last) t++;
        last = rxo;
      end
      check(t[7:0], ph ? 8'h00 : 8'h04, "rx toggles");
      uart_rx_busy = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
    rx_ind_enable = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(rxo, 8'h00, "rx disabled");
    $display("test rx done");
  endtask
  // Main sequence
  initial begin
    {nrst, cfg_load, cfg, wake_enable, rx_ind_enable, uart_rx_busy} = '0;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    test_reset();
    test_status();
    test_midreset();
    test_wake();
    test_rx();
    stop_test();
  end
endmodule
